// ==== core/sep_defs.svh ====
/*
 constants of the serial program port: command codes, frame positions,
 memory sizes, reset values and timing counts.
 assumes a 100 MHz core clock.
*/
`ifndef SEP_DEFS_SVH
`define SEP_DEFS_SVH

// pin positions inside the synchroniser vectors
`define SEP_PIN_DAT        0
`define SEP_PIN_CLK        1
`define SEP_PIN_MODE       2

// six-bit commands, value as written msb first
`define SEP_CMD_LOAD_CFG   6'h00
`define SEP_CMD_LOAD_ENC   6'h03
`define SEP_CMD_READ_CFG   6'h04
`define SEP_CMD_READ_ENC   6'h05
`define SEP_CMD_INC        6'h06
`define SEP_CMD_ERASE_PROG 6'h08
`define SEP_CMD_PROG_ONLY  6'h0a
`define SEP_CMD_BULK       6'h0b
`define SEP_CMD_LAST_BIT   5'h05

// frame positions, counted in clock cycles from 1
`define SEP_DATA_FIRST     5'h02
`define SEP_DATA_LAST      5'h0d
`define SEP_FRAME_LEN      5'h10

// pointer and memories
`define SEP_PTR_ENTRY      10'h3ff
`define SEP_ENC_DEPTH      8'h40
`define SEP_CFG_DEPTH      10'h010
`define SEP_CFG_WORD_IDX   4'h8
`define SEP_EP_BIT         6
`define SEP_ERASED         8'hff
`define SEP_CFG_RESET      12'hfff

// timing
`define SEP_CLK_MHZ        100
`define SEP_BULK_MS        10
`define SEP_PROG_US        5000
`define SEP_BULK_CYCLES    (`SEP_BULK_MS * 1000 * `SEP_CLK_MHZ)
`define SEP_PROG_CYCLES    (`SEP_PROG_US * `SEP_CLK_MHZ)
`define SEP_BUSY_W         20

`endif

// ==== core/sep_pkg.sv ====
/*
 types of the serial program port: phases, pending operations and the
 single packed state record of the core.
 assumes sep_defs.svh for widths.
*/
`include "sep_defs.svh"
package sep_pkg;

    typedef enum logic [1:0] {
        sep_idle,
        sep_cmd,
        sep_rdata,
        sep_ldata
    } sep_phase_t;

    typedef enum logic [1:0] {
        sep_op_none,
        sep_op_erase_prog,
        sep_op_prog_only,
        sep_op_bulk
    } sep_op_t;

    typedef enum logic [1:0] {
        sep_ld_none,
        sep_ld_cfg,
        sep_ld_enc
    } sep_load_t;

    typedef struct packed {
        logic [2:0]                sync1;
        logic [2:0]                sync2;
        logic [2:0]                sync3;
        logic [2:0]                pin;
        sep_phase_t                phase;
        logic [4:0]                cnt;
        logic [5:0]                cmd_sh;
        logic [11:0]               sh;
        logic [11:0]               latch;
        sep_load_t                 load_kind;
        logic [9:0]                ptr;
        logic                      bulk_armed;
        sep_op_t                   op;
        logic [`SEP_BUSY_W-1:0]    busy_cnt;
        logic                      busy;
        logic                      dout;
        logic                      doe;
        logic [63:0][7:0]          enc;
        logic [15:0][11:0]         cfg;
    } sep_state_t;

endpackage : sep_pkg

// ==== core/sep_port.sv ====
/*
 serial program port core: pin synchronisers, command shifter, data frame
 engine, shared pointer, encoder and configuration memories, protection.
 assumes the programmer clock and data pins and the mode select level
 arrive unsynchronised; the data pin is split into in, out and enable.
*/
// Operation
// RL1 - six-bit command, bits taken on falling clock edge, lsb first
// RL2 - programmer leaves one microsecond after each command
// RL3 - data frame is 16 cycles: start, 12 data, two zeros, stop
// RL4 - data lsb first, driven on rise, sampled on fall, first in cycle two
// RL5 - 000000 loads configuration data, 000011 loads encoder data
// RL6 - 000100 reads configuration, 000101 reads encoder, both with a frame
// RL7 - 000110 increments, 001000 erases and programs, 001010 programs only
// RL8 - 001011 arms bulk erase; other codes are reserved
// RL9 - configuration load sets pointer to 3ff, then takes 12 bits
// RL10 - encoder load keeps the first eight data bits only
// RL11 - encoder addressed by low eight pointer bits; 40h-ffh read zero
// RL12 - read drives data pin from second rise until frame end
// RL13 - configuration reads ignore the protection bit
// RL14 - protection makes encoder reads zero and blocks encoder writes
// RL15 - increment command advances the shared pointer by one
// RL16 - a load precedes each program command; erase then write, self-timed
// RL17 - program-only writes the loaded word without erasing first
// RL18 - programmer should bulk erase before program-only series
// RL19 - after bulk erase command the next program erases all encoder memory
// RL20 - configuration word written only if protection bit value changes
// RL21 - protection bit is bit 6; 0 to 1 unprotects and bulk erases
// RL22 - programmer preserves reserved configuration bits
// RL23 - entry with clock and data low while mode pin rises; pointer 3ff
// RL24 - bulk erase sets every encoder location to 0ffh
// RL25 - reserved command codes change nothing
`timescale 1ns/1ps
`include "sep_defs.svh"
module sep_port #(
    parameter int unsigned BULK_CYCLES = `SEP_BULK_CYCLES,
    parameter int unsigned PROG_CYCLES = `SEP_PROG_CYCLES
) (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic mode_select_pin,
    input  wire logic serial_clock_pin,
    input  wire logic serial_data_pin_in,
    output wire logic serial_data_pin_out,
    output wire logic serial_data_pin_oe,
    output wire logic encoder_protect_bit,
    output wire logic prog_busy
);

    sep_pkg::sep_state_t st;
    sep_pkg::sep_state_t next_st;
    logic [2:0]          filt;
    logic                rise;
    logic                fall;
    logic                din;
    logic [5:0]          cmd;
    logic [4:0]          idx;
    logic [7:0]          enc_addr;
    logic                unprot;
    logic [11:0]         old_cfg;

    always_comb begin
        next_st  = st;
        filt     = st.pin;
        // a pin change counts once the second and third stages agree
        for (int i = 0; i < 3; i++) begin
            if (st.sync2[i] == st.sync3[i]) begin
                filt[i] = st.sync2[i];
            end
        end
        next_st.sync1 = {mode_select_pin, serial_clock_pin, serial_data_pin_in};
        next_st.sync2 = st.sync1;
        next_st.sync3 = st.sync2;
        next_st.pin   = filt;
        rise     = filt[`SEP_PIN_CLK] & ~st.pin[`SEP_PIN_CLK];
        fall     = ~filt[`SEP_PIN_CLK] & st.pin[`SEP_PIN_CLK];
        din      = filt[`SEP_PIN_DAT];
        cmd      = {din, st.cmd_sh[5:1]}; // see RL1
        idx      = st.cnt + 5'h01;
        enc_addr = st.ptr[7:0]; // see RL11
        unprot   = st.cfg[`SEP_CFG_WORD_IDX][`SEP_EP_BIT];
        old_cfg  = st.cfg[st.ptr[3:0]];

        // self-timed completion of a program cycle
        if (st.busy_cnt != '0) begin
            next_st.busy_cnt = st.busy_cnt - `SEP_BUSY_W'(1);
        end
        if (st.busy_cnt == `SEP_BUSY_W'(1)) begin
            next_st.busy      = 1'b0;
            next_st.op        = sep_pkg::sep_op_none;
            next_st.load_kind = sep_pkg::sep_ld_none;
            if (st.op == sep_pkg::sep_op_bulk) begin
                if (unprot) begin // see RL14
                    for (int j = 0; j < 64; j++) begin
                        next_st.enc[j] = `SEP_ERASED; // see RL19 RL24
                    end
                end
            end else if (st.load_kind == sep_pkg::sep_ld_enc) begin
                if (unprot && enc_addr < `SEP_ENC_DEPTH) begin // see RL14
                    if (st.op == sep_pkg::sep_op_prog_only) begin
                        // no erase: programming can only clear bits
                        next_st.enc[enc_addr[5:0]] =
                            st.enc[enc_addr[5:0]] & st.latch[7:0]; // see RL17
                    end else begin
                        next_st.enc[enc_addr[5:0]] = st.latch[7:0]; // see RL16
                    end
                end
            end else if (st.ptr < `SEP_CFG_DEPTH) begin
                if (st.ptr[3:0] != `SEP_CFG_WORD_IDX) begin
                    next_st.cfg[st.ptr[3:0]] = st.latch;
                end else if (st.latch[`SEP_EP_BIT] != old_cfg[`SEP_EP_BIT]) begin
                    next_st.cfg[st.ptr[3:0]] = st.latch; // see RL20
                    if (st.latch[`SEP_EP_BIT]) begin
                        for (int j = 0; j < 64; j++) begin
                            next_st.enc[j] = `SEP_ERASED; // see RL21 RL24
                        end
                    end
                end
            end
        end

        case (st.phase)
            sep_pkg::sep_idle: begin
                if (filt[`SEP_PIN_MODE] & ~filt[`SEP_PIN_CLK]
                    & ~filt[`SEP_PIN_DAT]) begin
                    next_st.phase = sep_pkg::sep_cmd;
                    next_st.ptr   = `SEP_PTR_ENTRY; // see RL23
                    next_st.cnt   = 5'h00;
                end
            end
            sep_pkg::sep_cmd: begin
                if (fall) begin
                    next_st.cmd_sh = cmd;
                    next_st.cnt    = idx;
                    if (st.cnt == `SEP_CMD_LAST_BIT) begin // see RL1
                        next_st.cnt = 5'h00;
                        next_st.sh  = 12'h000;
                        // commands that arrive during a program cycle are dropped
                        if (!st.busy) begin
                            case (cmd)
                                `SEP_CMD_LOAD_CFG: begin
                                    next_st.ptr   = `SEP_PTR_ENTRY; // see RL9
                                    next_st.phase = sep_pkg::sep_ldata; // see RL5
                                end
                                `SEP_CMD_LOAD_ENC: begin
                                    next_st.phase = sep_pkg::sep_ldata; // see RL5
                                end
                                `SEP_CMD_READ_CFG: begin
                                    if (st.ptr < `SEP_CFG_DEPTH) begin
                                        next_st.sh = old_cfg; // see RL13
                                    end
                                    next_st.phase = sep_pkg::sep_rdata; // see RL6
                                end
                                `SEP_CMD_READ_ENC: begin
                                    if (unprot && enc_addr < `SEP_ENC_DEPTH) begin
                                        next_st.sh = {4'h0, st.enc[enc_addr[5:0]]}; // see RL14
                                    end
                                    next_st.phase = sep_pkg::sep_rdata; // see RL6
                                end
                                `SEP_CMD_INC: begin
                                    next_st.ptr = st.ptr + 10'h001; // see RL15 RL7
                                end
                                `SEP_CMD_ERASE_PROG,
                                `SEP_CMD_PROG_ONLY: begin
                                    next_st.busy = 1'b1;
                                    if (st.bulk_armed) begin
                                        next_st.bulk_armed = 1'b0;
                                        next_st.op         = sep_pkg::sep_op_bulk; // see RL19
                                        next_st.busy_cnt   = `SEP_BUSY_W'(BULK_CYCLES);
                                    end else if (st.load_kind != sep_pkg::sep_ld_none) begin
                                        next_st.busy_cnt = `SEP_BUSY_W'(PROG_CYCLES); // see RL16
                                        if (cmd == `SEP_CMD_PROG_ONLY) begin
                                            next_st.op = sep_pkg::sep_op_prog_only; // see RL7
                                        end else begin
                                            next_st.op = sep_pkg::sep_op_erase_prog;
                                        end
                                    end else begin
                                        next_st.busy = 1'b0;
                                    end
                                end
                                `SEP_CMD_BULK: begin
                                    next_st.bulk_armed = 1'b1; // see RL8
                                end
                                default: begin
                                    next_st.phase = sep_pkg::sep_cmd; // see RL25
                                end
                            endcase
                        end
                    end
                end
            end
            sep_pkg::sep_rdata: begin
                if (rise && idx >= `SEP_DATA_FIRST) begin
                    next_st.doe  = 1'b1; // see RL12
                    next_st.dout = st.sh[0]; // see RL4
                    next_st.sh   = {1'b0, st.sh[11:1]};
                end
                if (fall) begin
                    next_st.cnt = idx;
                    if (idx == `SEP_FRAME_LEN) begin // see RL3
                        next_st.doe   = 1'b0; // see RL12
                        next_st.dout  = 1'b0;
                        next_st.cnt   = 5'h00;
                        next_st.phase = sep_pkg::sep_cmd;
                    end
                end
            end
            sep_pkg::sep_ldata: begin
                if (fall) begin
                    next_st.cnt = idx;
                    if (idx >= `SEP_DATA_FIRST && idx <= `SEP_DATA_LAST) begin
                        next_st.sh = {din, st.sh[11:1]}; // see RL4
                    end
                    if (idx == `SEP_FRAME_LEN) begin // see RL3 RL10
                        next_st.cnt   = 5'h00;
                        next_st.phase = sep_pkg::sep_cmd;
                        if (st.cmd_sh == `SEP_CMD_LOAD_ENC) begin
                            next_st.latch     = {4'h0, st.sh[7:0]}; // see RL10
                            next_st.load_kind = sep_pkg::sep_ld_enc;
                        end else begin
                            next_st.latch     = st.sh; // see RL9
                            next_st.load_kind = sep_pkg::sep_ld_cfg;
                        end
                    end
                end
            end
            default: begin
                next_st.phase = sep_pkg::sep_idle;
            end
        endcase

        // leaving program mode abandons any frame and frees the pin
        if (!filt[`SEP_PIN_MODE]) begin
            next_st.phase = sep_pkg::sep_idle;
            next_st.doe   = 1'b0;
            next_st.dout  = 1'b0;
            next_st.cnt   = 5'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st     <= '0;
            st.ptr <= `SEP_PTR_ENTRY;
            st.enc <= {64{`SEP_ERASED}};
            st.cfg <= {16{`SEP_CFG_RESET}};
        end else begin
            st <= next_st;
        end
    end

    assign serial_data_pin_out = st.dout;
    assign serial_data_pin_oe  = st.doe;
    assign encoder_protect_bit = st.cfg[`SEP_CFG_WORD_IDX][`SEP_EP_BIT];
    assign prog_busy           = st.busy;

endmodule : sep_port

// ==== verification/sep_port_properties.sv ====
/*
 checker of the serial program port: data pin window and pads, program
 timer length and the moment the protection bit may move.
 assumes it is bound to sep_port and sees only its ports.
*/
`timescale 1ns/1ps
module sep_port_checker #(
    parameter int unsigned BULK_CYCLES = 20,
    parameter int unsigned PROG_CYCLES = 10
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic mode_select_pin,
    input wire logic serial_clock_pin,
    input wire logic serial_data_pin_in,
    input wire logic serial_data_pin_out,
    input wire logic serial_data_pin_oe,
    input wire logic encoder_protect_bit,
    input wire logic prog_busy
);
    logic        sck_q;
    logic [7:0]  since_fall;
    logic [4:0]  rise_cnt;
    logic [31:0] run;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // raw pin edges, rises counted only while the pin is driven
    always_ff @(posedge clk) begin
        sck_q <= serial_clock_pin;
        if (reset || (sck_q && !serial_clock_pin))
            since_fall <= 8'h00;
        else if (since_fall != 8'hff)
            since_fall <= since_fall + 8'h01;
        if (reset || !serial_data_pin_oe)
            rise_cnt <= 5'h00;
        else if (serial_clock_pin && !sck_q)
            rise_cnt <= rise_cnt + 5'h01;
        if (reset || !prog_busy)
            run <= 32'h0;
        else
            run <= run + 32'h1;
    end
    sequence s_mode_gone;
        !mode_select_pin [*8];
    endsequence
    a_mode_release: assert property (s_mode_gone |-> !serial_data_pin_oe)
        else $error("data pin driven outside program mode");
    a_out_quiet: assert property (!serial_data_pin_oe |-> !serial_data_pin_out)
        else $error("data output high while released");
    a_oe_window: assert property ($fell(serial_data_pin_oe) |-> rise_cnt == 5'h0e)
        else $error("read frame drive window wrong");
    a_oe_bound: assert property (serial_data_pin_oe |-> rise_cnt <= 5'h0e)
        else $error("data pin held past frame end");
    a_read_pad: assert property (serial_data_pin_oe && rise_cnt >= 5'h0d |-> !serial_data_pin_out)
        else $error("pad or stop bit not zero");
    a_busy_len: assert property ($fell(prog_busy) |->
        (run + 2 >= PROG_CYCLES && run <= PROG_CYCLES + 2)
        || (run + 2 >= BULK_CYCLES && run <= BULK_CYCLES + 2))
        else $error("program timer length wrong");
    a_busy_no_read: assert property (prog_busy |-> !serial_data_pin_oe)
        else $error("data pin driven during program");
    a_busy_start: assert property ($rose(prog_busy) |-> since_fall <= 8'h08)
        else $error("program started away from a command");
    a_ep_at_end: assert property ($changed(encoder_protect_bit) |-> $past(prog_busy) || $past(prog_busy, 2))
        else $error("protection bit moved outside a program cycle");
endmodule : sep_port_checker
bind sep_port sep_port_checker #(.BULK_CYCLES(BULK_CYCLES), .PROG_CYCLES(PROG_CYCLES))
    chk_u (.clk(clk), .reset(reset), .mode_select_pin(mode_select_pin),
    .serial_clock_pin(serial_clock_pin), .serial_data_pin_in(serial_data_pin_in),
    .serial_data_pin_out(serial_data_pin_out), .serial_data_pin_oe(serial_data_pin_oe),
    .encoder_protect_bit(encoder_protect_bit), .prog_busy(prog_busy));

// ==== verification/sep_prog_model.sv ====
/*
 programmer model: drives the serial clock and data pin, clocks commands
 and frames, samples read frames; the clock stands low between frames.
 assumes its tasks start on a falling core clock edge.
*/
`timescale 1ns/1ps
module sep_prog_model (
    output logic      serial_clock_pin,
    output logic      dat,
    output logic      dat_oe,
    input  wire logic lvl
);
    initial begin
        serial_clock_pin = 1'b0;
        dat = 1'b0;
        dat_oe = 1'b1;
    end
    task automatic cyc(input logic b);
        serial_clock_pin = 1'b1;
        dat = b;
        #40;
        serial_clock_pin = 1'b0;
        #40;
    endtask : cyc
    task automatic send_cmd(input logic [5:0] c);
        for (int i = 0; i < 6; i++) begin
            cyc(c[i]);
        end
        dat = 1'b0;
        #1000;
    endtask : send_cmd
    task automatic put_frame(input logic [11:0] w);
        logic [15:0] f;
        f = {3'h0, w, 1'h0};
        for (int i = 0; i < 16; i++) begin
            cyc(f[i]);
        end
        dat = 1'b0;
        #1000;
    endtask : put_frame
    task automatic get_frame(output logic [11:0] w);
        dat_oe = 1'b0;
        for (int i = 0; i < 16; i++) begin
            serial_clock_pin = 1'b1;
            #40;
            serial_clock_pin = 1'b0;
            #40;
            if (i >= 1 && i <= 12)
                w[i-1] = lvl;
        end
        #1000;
        dat_oe = 1'b1;
    endtask : get_frame
endmodule : sep_prog_model

// ==== verification/tb_top.sv ====
/*
 testbench top: core clock, reset, mode select and one task per scenario.
 assumes sep_port, its bound checker and sep_prog_model are compiled.
*/
`timescale 1ns/1ps
`include "sep_defs.svh"
module tb_top;
    logic        clk;
    logic        reset;
    logic        mode_select_pin;
    logic        sclk;
    logic        p_dat;
    logic        p_oe;
    logic        flip;
    logic        d_out;
    logic        d_oe;
    logic        ep;
    logic        busy;
    logic [11:0] rw;
    wire logic   lvl;
    int          err_count;
    int          comparisons;
    // a released data line wanders instead of keeping its last level
    assign lvl = d_oe ? d_out : (p_oe ? p_dat : flip);
    sep_port #(.BULK_CYCLES(400), .PROG_CYCLES(200)) dut_u (.clk(clk), .reset(reset),
        .mode_select_pin(mode_select_pin), .serial_clock_pin(sclk), .serial_data_pin_in(lvl),
        .serial_data_pin_out(d_out), .serial_data_pin_oe(d_oe), .encoder_protect_bit(ep),
        .prog_busy(busy));
    sep_prog_model prg_u (.serial_clock_pin(sclk), .dat(p_dat), .dat_oe(p_oe), .lvl(lvl));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) flip <= (flip !== 1'b1);
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic give_verdict();
        $display("comparisons=%0d mismatches=%0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : give_verdict
    task automatic enter();
        mode_select_pin = 1'b0;
        repeat (10) @(negedge clk);
        mode_select_pin = 1'b1;
        repeat (10) @(negedge clk);
    endtask : enter
    task automatic rd(input logic [5:0] c);
        prg_u.send_cmd(c);
        prg_u.get_frame(rw);
    endtask : rd
    task automatic ld(input logic [5:0] c, input logic [11:0] w);
        prg_u.send_cmd(c);
        prg_u.put_frame(w);
    endtask : ld
    task automatic prog(input logic [5:0] c);
        int n;
        n = 0;
        prg_u.send_cmd(c);
        chk({11'h000, busy}, 12'h001);
        while (busy !== 1'b0 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 2000) begin
            err_count++;
            give_verdict();
        end
    endtask : prog
    task automatic cfg_write(input logic [11:0] w);
        ld(`SEP_CMD_LOAD_CFG, w);
        repeat (9) prg_u.send_cmd(`SEP_CMD_INC);
        prog(`SEP_CMD_ERASE_PROG);
    endtask : cfg_write
    task automatic t_entry();
        enter();
        chk({11'h000, ep}, 12'h001);
        rd(`SEP_CMD_READ_CFG);
        chk(rw, 12'h000);
        rd(`SEP_CMD_READ_ENC);
        chk(rw, 12'h000);
        prg_u.send_cmd(`SEP_CMD_INC);
        rd(`SEP_CMD_READ_ENC);
        chk(rw, 12'h0ff);
        $display("entry test done");
    endtask : t_entry
    task automatic t_program();
        ld(`SEP_CMD_LOAD_ENC, 12'ha5c);
        prog(`SEP_CMD_ERASE_PROG);
        rd(`SEP_CMD_READ_ENC);
        chk(rw, 12'h05c);
        ld(`SEP_CMD_LOAD_ENC, 12'h0f3);
        prog(`SEP_CMD_PROG_ONLY);
        rd(`SEP_CMD_READ_ENC);
        chk(rw, 12'h050);
        prg_u.send_cmd(6'h3f);
        prg_u.send_cmd(6'h07);
        rd(`SEP_CMD_READ_ENC);
        chk(rw, 12'h050);
        prg_u.send_cmd(`SEP_CMD_BULK);
        ld(`SEP_CMD_LOAD_ENC, 12'h012);
        prog(`SEP_CMD_ERASE_PROG);
        rd(`SEP_CMD_READ_ENC);
        chk(rw, 12'h0ff);
        // program-only series started on a freshly erased memory
        ld(`SEP_CMD_LOAD_ENC, 12'h03c);
        prog(`SEP_CMD_PROG_ONLY);
        rd(`SEP_CMD_READ_ENC);
        chk(rw, 12'h03c);
        repeat (64) prg_u.send_cmd(`SEP_CMD_INC);
        rd(`SEP_CMD_READ_ENC);
        chk(rw, 12'h000);
        $display("program test done");
    endtask : t_program
    task automatic t_protect();
        enter();
        prg_u.send_cmd(`SEP_CMD_INC);
        ld(`SEP_CMD_LOAD_ENC, 12'h03c);
        prog(`SEP_CMD_ERASE_PROG);
        cfg_write(12'hfbf);
        chk({11'h000, ep}, 12'h000);
        rd(`SEP_CMD_READ_CFG);
        chk(rw, 12'hfbf);
        cfg_write(12'hfb0);
        rd(`SEP_CMD_READ_CFG);
        chk(rw, 12'hfbf);
        enter();
        prg_u.send_cmd(`SEP_CMD_INC);
        rd(`SEP_CMD_READ_ENC);
        chk(rw, 12'h000);
        cfg_write(12'hfff);
        chk({11'h000, ep}, 12'h001);
        enter();
        prg_u.send_cmd(`SEP_CMD_INC);
        rd(`SEP_CMD_READ_ENC);
        chk(rw, 12'h0ff);
        $display("protect test done");
    endtask : t_protect
    initial begin
        err_count = 0;
        comparisons = 0;
        reset = 1'b1;
        mode_select_pin = 1'b0;
        repeat (10) @(negedge clk);
        reset = 1'b0;
        t_entry();
        t_program();
        t_protect();
        give_verdict();
    end
endmodule : tb_top
